// >>> hdl/ifl_intc.sv
`timescale 1ns/10ps
module ifl_intc
  import ifl_pkg::*;
#(
  parameter logic [7:0] VEC_BASE = 8'h40,
  parameter logic [7:0] VEC_SPURIOUS = 8'h18
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [IFL_AW-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Peripheral request lines, index is the source number
  input wire logic [63:1] src_req,
  // Level summary of the peer controller
  input wire logic [7:1] peer_level_req,
  // Processor core side
  output logic [2:0] ipl,
  input wire logic ack_req,
  input wire logic [2:0] ack_level,
  output logic ack_valid,
  output logic [7:0] ack_vector
);

  // Timing overview, all counted in mclk edges.
  // A request line seen at edge e is pending at e, so the summary
  // register shows it at e+1 and the core level follows at e+2.
  // A force or mask write at edge e follows the same path, since
  // the active vector is formed from the register contents alone.
  // The peer summary enters only the last stage, so it reaches the
  // core level at the same edge that samples it.
  // An acknowledge taken at edge e answers at e with a one-cycle
  // valid pulse; the vector and the capture register then hold
  // until the next acknowledge, so the core may read them late.
  // The winner search looks at the active vector of the same edge
  // that takes the acknowledge, not at the registered summary.
  // That keeps the answer current even when the summary lags by a
  // cycle, at the cost of one wide combinational search path.
  // Acknowledge leaves pending and force bits alone; the source or
  // software clears its own request.
  // Control words of sources 1..7 are fixed at their own level and
  // are never written; their priority reads as zero although they
  // rank at the midpoint between programmed priorities 3 and 4.
  // A source whose level is still zero never counts, even forced,
  // so unused sources stay quiet without any mask setting.

  // Vector base plus the largest source number must fit a byte
  if (int'(VEC_BASE) + IFL_NUM_SRC > 255) begin : g_bad_base
    $error("vector base too large for 63 sources");
  end

  // The spurious vector must not alias a real source vector
  if (int'(VEC_SPURIOUS) > int'(VEC_BASE) &&
      int'(VEC_SPURIOUS) <= int'(VEC_BASE) + IFL_NUM_SRC) begin : g_bad_spur
    $error("spurious vector collides with a source vector");
  end

  // Fixed sources must all sit below the first writable one
  if (IFL_FIXED_LAST >= IFL_FIRST_WRITABLE) begin : g_bad_fixed
    $error("fixed sources overlap writable control registers");
  end

  // Control index test shared by write decode and read mux
  function automatic logic ctl_is_writable(input logic [5:0] idx);
    ctl_is_writable = idx >= 6'(IFL_FIRST_WRITABLE);
  endfunction

  // Highest set bit of a level vector, zero when empty
  function automatic logic [2:0] top_level(input logic [7:1] v);
    top_level = 3'h0;
    for (int k = 1; k <= 7; k++) begin
      if (v[k]) begin
        top_level = 3'(k);
      end
    end
  endfunction

  // Register state
  logic [31:0] force_high;
  logic [31:0] force_low;
  logic [31:0] mask_high;
  logic [31:0] mask_low;
  logic [63:0] pend;
  logic [7:0] level_request_summary;
  logic [7:0] ack_level_priority;
  logic [2:0] ctl_lvl [64];
  logic [2:0] ctl_pri [64];

  // Next values
  logic [7:0] next_level_sum;
  logic [31:0] next_rd;

  // Address decode
  wire logic wr_force_high = wr_en && addr == IFL_OFS_FORCE_HIGH;
  wire logic wr_force_low = wr_en && addr == IFL_OFS_FORCE_LOW;
  wire logic wr_mask_high = wr_en && addr == IFL_OFS_MASK_HIGH;
  wire logic wr_mask_low = wr_en && addr == IFL_OFS_MASK_LOW;
  wire logic ctl_hit = addr[IFL_AW-1] == IFL_OFS_CTRL_BASE[IFL_AW-1];
  wire logic [5:0] ctl_idx = addr[5:0];
  wire logic ctl_writable = ctl_hit && ctl_is_writable(ctl_idx);
  wire logic wr_ctl = wr_en && ctl_writable;
  wire logic global_mask_bit = wr_mask_low && wr_data[IFL_GLOBAL_MASK_BIT_BIT];

  // Combined views, bit index is the source number
  wire logic [63:0] force_all = {force_high, force_low[31:1], 1'b0};
  wire logic [63:0] mask_all = {mask_high, mask_low};
  // Force bypasses the mask entirely
  wire logic [63:0] req_raw = (pend & ~mask_all) | force_all;

  // A source with level zero is still disabled
  logic [63:0] active;
  always_comb begin
    active = 64'h0;
    for (int i = 1; i <= IFL_NUM_SRC; i++) begin
      active[i] = req_raw[i] && ctl_lvl[i] != 3'h0;
    end
  end

  // Force registers; reserved bit 0 of force_low never stores
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      force_high <= IFL_FORCE_RESET;
      force_low <= IFL_FORCE_RESET;
    end else begin
      if (wr_force_high) begin
        force_high <= wr_data;
      end
      if (wr_force_low) begin
        force_low <= {wr_data[31:1], 1'b0};
      end
    end
  end

  // Mask registers; writing the mask-all bit sets the other 63 too
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mask_high <= IFL_MASK_RESET;
      mask_low <= IFL_MASK_RESET;
    end else if (global_mask_bit) begin
      mask_high <= IFL_MASK_RESET;
      mask_low <= IFL_MASK_RESET;
    end else begin
      if (wr_mask_high) begin
        mask_high <= wr_data;
      end
      if (wr_mask_low) begin
        mask_low <= wr_data;
      end
    end
  end

  // Pending follows the request lines every clock, mask ignored
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pend <= 64'h0;
    end else begin
      pend <= {src_req, 1'b0};
    end
  end

  // Control registers; sources 1..7 are fixed at their own level
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < 64; i++) begin
        if (i >= 1 && i <= IFL_FIXED_LAST) begin
          ctl_lvl[i] <= 3'(i);
        end else begin
          ctl_lvl[i] <= IFL_CTL_RESET[5:3];
        end
        ctl_pri[i] <= IFL_CTL_RESET[2:0];
      end
    end else if (wr_ctl) begin
      ctl_lvl[ctl_idx] <= wr_data[IFL_CTL_LVL_LSB +: 3];
      ctl_pri[ctl_idx] <= wr_data[IFL_CTL_PRI_LSB +: 3];
    end
  end

  // Per-level summary of active requests
  always_comb begin
    next_level_sum = 8'h00;
    for (int i = 1; i <= IFL_NUM_SRC; i++) begin
      if (active[i]) begin
        next_level_sum[ctl_lvl[i]] = 1'b1;
      end
    end
    next_level_sum[0] = 1'b0;
  end

  // Summary register, then merge with the peer and encode for the core.
  // The core sees one extra cycle of latency, traded for a clean flop.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      level_request_summary <= 8'h00;
      ipl <= 3'h0;
    end else begin
      level_request_summary <= next_level_sum;
      ipl <= top_level(level_request_summary[7:1]
                       | peer_level_req);
    end
  end

  // Search for the acknowledge winner
  logic sel_found;
  logic [5:0] sel_src;
  logic [3:0] sel_pri;
  ifl_select u_select (
    .active(active),
    .src_lvl(ctl_lvl),
    .src_pri(ctl_pri),
    .want_lvl(ack_level),
    .found(sel_found),
    .win_src(sel_src),
    .win_pri(sel_pri)
  );

  wire logic [7:0] ack_vec_next =
    sel_found ? VEC_BASE + {2'b00, sel_src} : VEC_SPURIOUS;

  // Acknowledge answer and capture; no register write reaches capture.
  // With no winner the spurious vector goes out and the capture keeps
  // the acknowledged level beside a zero priority.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_valid <= 1'b0;
      ack_vector <= 8'h00;
      ack_level_priority <= IFL_ACK_LP_RESET;
    end else begin
      ack_valid <= ack_req;
      if (ack_req) begin
        ack_vector <= ack_vec_next;
        ack_level_priority <= {1'b0, ack_level, sel_pri};
      end
    end
  end

  // Read multiplexer; fixed sources show a zero priority field.
  // Reserved and unmapped bits read as zero, so software that masks
  // nothing still sees clean words.
  always_comb begin
    next_rd = 32'h0;
    if (ctl_hit) begin
      if (ctl_idx != 6'h00) begin
        next_rd[IFL_CTL_LVL_LSB +: 3] = ctl_lvl[ctl_idx];
        if (ctl_is_writable(ctl_idx)) begin
          next_rd[IFL_CTL_PRI_LSB +: 3] = ctl_pri[ctl_idx];
        end
      end
    end else begin
      case (addr)
        IFL_OFS_FORCE_HIGH: next_rd = force_high;
        IFL_OFS_FORCE_LOW: next_rd = force_low;
        IFL_OFS_MASK_HIGH: next_rd = mask_high;
        IFL_OFS_MASK_LOW: next_rd = mask_low;
        IFL_OFS_PEND_HIGH: next_rd = pend[63:32];
        IFL_OFS_PEND_LOW: next_rd = pend[31:0];
        IFL_OFS_LEVEL_REQ: next_rd = {24'h0, level_request_summary};
        IFL_OFS_ACK_LP: next_rd = {24'h0, ack_level_priority};
        default: next_rd = 32'h0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= rd_en ? next_rd : 32'h0;
    end
  end

endmodule

// >>> hdl/ifl_pkg.sv
package ifl_pkg;

  // Register word addresses on the plain register port
  localparam int IFL_AW = 7;
  localparam logic [6:0] IFL_OFS_FORCE_HIGH = 7'h00;
  localparam logic [6:0] IFL_OFS_FORCE_LOW = 7'h01;
  localparam logic [6:0] IFL_OFS_MASK_HIGH = 7'h02;
  localparam logic [6:0] IFL_OFS_MASK_LOW = 7'h03;
  localparam logic [6:0] IFL_OFS_PEND_HIGH = 7'h04;
  localparam logic [6:0] IFL_OFS_PEND_LOW = 7'h05;
  localparam logic [6:0] IFL_OFS_LEVEL_REQ = 7'h06;
  localparam logic [6:0] IFL_OFS_ACK_LP = 7'h07;
  // Source control x sits at IFL_OFS_CTRL_BASE + x, x = 1..63
  localparam logic [6:0] IFL_OFS_CTRL_BASE = 7'h40;

  // Source control fields
  localparam int IFL_CTL_LVL_LSB = 3;
  localparam int IFL_CTL_PRI_LSB = 0;
  // Acknowledge capture fields
  localparam int IFL_ACK_LVL_LSB = 4;
  localparam int IFL_ACK_PRI_LSB = 0;
  // Mask-all bit in mask_low
  localparam int IFL_GLOBAL_MASK_BIT_BIT = 0;

  // Source counts
  localparam int IFL_NUM_SRC = 63;
  localparam int IFL_FIXED_LAST = 7;
  localparam int IFL_FIRST_WRITABLE = 8;

  // Reset values
  localparam logic [31:0] IFL_FORCE_RESET = 32'h0000_0000;
  localparam logic [31:0] IFL_MASK_RESET = 32'hffff_ffff;
  localparam logic [5:0] IFL_CTL_RESET = 6'h00;
  localparam logic [7:0] IFL_ACK_LP_RESET = 8'h00;

  // Priority encodings
  localparam logic [3:0] IFL_PRI_MID = 4'h8;
  localparam logic [3:0] IFL_RANK_MID = 4'h7;

endpackage

// >>> hdl/ifl_select.sv
`timescale 1ns/10ps
// Finds the highest ranked active source at one requested level
module ifl_select
  import ifl_pkg::*;
(
  // Source state
  input wire logic [63:0] active,
  input wire logic [2:0] src_lvl [64],
  input wire logic [2:0] src_pri [64],
  // Query
  input wire logic [2:0] want_lvl,
  // Result
  output logic found,
  output logic [5:0] win_src,
  output logic [3:0] win_pri
);

  // Fixed-level sources sit between programmed priorities 3 and 4
  function automatic logic [3:0] rank_of(input int idx,
                                         input logic [2:0] acked_priority_field);
    rank_of = (idx <= IFL_FIXED_LAST) ? IFL_RANK_MID : {acked_priority_field, 1'b0};
  endfunction

  // Strict compare keeps the lowest index on a tie; ties are misuse
  always_comb begin
    logic [3:0] best;
    logic [3:0] r;
    best = 4'h0;
    r = 4'h0;
    found = 1'b0;
    win_src = 6'h00;
    win_pri = 4'h0;
    for (int i = 1; i <= IFL_NUM_SRC; i++) begin
      r = rank_of(i, src_pri[i]);
      if (active[i] && src_lvl[i] == want_lvl && want_lvl != 3'h0 &&
          (!found || r > best)) begin
        found = 1'b1;
        best = r;
        win_src = 6'(i);
        win_pri = (i <= IFL_FIXED_LAST) ? IFL_PRI_MID
                                         : {1'b0, src_pri[i]};
      end
    end
  end

endmodule

// >>> verification/ifl_intc_asserts.sv
`timescale 1ns/10ps
module ifl_intc_asserts
  import ifl_pkg::*;
#(
  parameter logic [7:0] VEC_SPURIOUS = 8'h18
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register read side
  input wire logic [IFL_AW-1:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // Core side
  input wire logic [7:1] peer_level_req,
  input wire logic [2:0] ipl,
  input wire logic ack_req,
  input wire logic [2:0] ack_level,
  input wire logic ack_valid,
  input wire logic [7:0] ack_vector
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Peer request held across the edge that samples it
  sequence s_peer_top;
    peer_level_req[7] [*2];
  endsequence
  a_ack_answer: assert property (ack_req |=> ack_valid)
    else $error("no ack answer");
  a_ack_pulse: assert property (!ack_req |=> !ack_valid)
    else $error("stray ack");
  a_vector_held: assert property (!ack_req |=> $stable(ack_vector))
    else $error("vector moved");
  a_spur_vector: assert property (
    ack_req && ack_level == 3'h0 |=> ack_vector == VEC_SPURIOUS)
    else $error("bad spurious vector");
  a_summary_bit0: assert property (
    rd_en && addr == IFL_OFS_LEVEL_REQ |=> rd_data[0] == 1'b0)
    else $error("summary bit 0 set");
  a_capture_fields: assert property (
    rd_en && addr == IFL_OFS_ACK_LP |=> !rd_data[7] && rd_data[3:0] <= 4'h8)
    else $error("capture field out of range");
  a_fixed_prio: assert property (
    rd_en && addr > IFL_OFS_CTRL_BASE && addr < IFL_OFS_CTRL_BASE + 7'h08
    |=> rd_data[2:0] == 3'h0)
    else $error("fixed priority not zero");
  a_peer_level: assert property (s_peer_top |=> ipl == 3'h7)
    else $error("peer level lost");
endmodule

bind ifl_intc ifl_intc_asserts #(.VEC_SPURIOUS(VEC_SPURIOUS)) chk_i (
  .mclk, .nrst, .addr, .rd_en, .rd_data, .peer_level_req, .ipl, .ack_req,
  .ack_level, .ack_valid, .ack_vector);

// >>> verification/ifl_core_model.sv
`timescale 1ns/10ps
// Core that acknowledges on command, at once or late
module ifl_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bench control
  input wire logic go,
  input wire logic [2:0] lvl,
  input wire logic [1:0] slow,
  // Acknowledge cycle
  output logic ack_req,
  output logic [2:0] ack_level
);
  logic armed;
  logic [1:0] cnt;
  // Idle level toggles so a stale value is never trusted
  always_ff @(posedge mclk) begin
    ack_req <= 1'b0;
    if (!nrst) begin
      armed <= 1'b0;
      ack_level <= 3'h0;
    end else if (go) begin
      armed <= 1'b1;
      cnt <= slow;
      ack_level <= lvl;
    end else if (armed && cnt == 2'h0) begin
      armed <= 1'b0;
      ack_req <= 1'b1;
    end else if (armed) begin
      cnt <= cnt - 2'h1;
    end else begin
      ack_level <= ~ack_level;
    end
  end
endmodule

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
  import ifl_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, go = 1'b0;
  logic rd_pend = 1'b0, ack_req, ack_valid;
  logic [IFL_AW-1:0] addr = 7'h00;
  logic [31:0] wr_data = 32'h0, rd_data, rnd;
  logic [63:1] src_req = 63'h0;
  logic [7:1] peer_level_req = 7'h00;
  logic [2:0] ipl, ack_level, lvl = 3'h0, acked_priority_field;
  logic [1:0] slow = 2'h0;
  logic [7:0] ack_vector;
  logic [31:0] q_rd[$], q_ack[$];
  int n_mismatch = 0, checks_done = 0;

  ifl_intc ifl_intc_i (.mclk, .nrst, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .src_req, .peer_level_req, .ipl, .ack_req, .ack_level,
    .ack_valid, .ack_vector);
  ifl_core_model ifl_core_model_i (.mclk, .nrst, .go, .lvl, .slow,
    .ack_req, .ack_level);

  always #12.5 mclk = ~mclk;

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One compare task per kind of result
  task automatic cmp_rd(logic [31:0] exp, logic [31:0] got);
    cmp("rd_data", exp, got);
  endtask

  task automatic cmp_ack(logic [31:0] exp, logic [7:0] got);
    cmp("ack_vector", exp, {24'h0, got});
  endtask

  task automatic cmp_ipl(logic [2:0] exp);
    cmp("ipl", {29'h0, exp}, {29'h0, ipl});
  endtask

  // Strobes drop for a cycle so no signal is driven twice per step
  task automatic wr(logic [6:0] a, logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(logic [6:0] a, logic [31:0] exp);
    q_rd.push_back(exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic ack(logic [2:0] l, logic [1:0] s, logic [7:0] exp);
    int i;
    q_ack.push_back({24'h0, exp});
    lvl <= l;
    slow <= s;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (i = 0; i < 20 && ack_valid !== 1'b1; i++)
      @(posedge mclk);
    if (i < 20)
      @(posedge mclk);
    else begin
      n_mismatch++;
      final_report();
    end
  endtask

  // Results checked against the oldest note when they appear
  always @(posedge mclk) begin
    if (rd_pend)
      cmp_rd(q_rd.pop_front(), rd_data);
    if (ack_valid === 1'b1)
      cmp_ack(q_ack.pop_front(), ack_vector);
    rd_pend <= rd_en;
  end

  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h5c553aad));
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // Reset contents, an unmapped word and the access kinds
    rd(IFL_OFS_FORCE_LOW, 32'h0);
    rd(IFL_OFS_ACK_LP, 32'h0);
    rd(IFL_OFS_CTRL_BASE + 7'h03, 32'h18);
    rd(IFL_OFS_CTRL_BASE + 7'h08, 32'h0);
    rd(7'h10, 32'h0);
    wr(IFL_OFS_CTRL_BASE + 7'h08, 32'hff);
    rd(IFL_OFS_CTRL_BASE + 7'h08, 32'h3f);
    wr(IFL_OFS_CTRL_BASE + 7'h03, 32'h3f);
    rd(IFL_OFS_CTRL_BASE + 7'h03, 32'h18);
    wr(IFL_OFS_ACK_LP, 32'h7f);
    rd(IFL_OFS_ACK_LP, 32'h0);
    // Random force and request words on unassigned sources, then all ones to force_low
    rnd = $urandom;
    wr(IFL_OFS_FORCE_HIGH, rnd);
    rd(IFL_OFS_FORCE_HIGH, rnd);
    src_req[63:32] <= rnd;
    @(posedge mclk);
    rd(IFL_OFS_PEND_HIGH, rnd);
    wr(IFL_OFS_FORCE_LOW, 32'hffffffff);
    rd(IFL_OFS_FORCE_LOW, 32'hfffffffe);
    // Two forced masked sources share a level, unique priorities
    wr(IFL_OFS_CTRL_BASE + 7'h09, 32'h2a);
    wr(IFL_OFS_CTRL_BASE + 7'h0a, 32'h2e);
    wr(IFL_OFS_FORCE_LOW, 32'h600);
    rd(IFL_OFS_LEVEL_REQ, 32'h20);
    cmp_ipl(3'h5);
    ack(3'h5, 2'h0, 8'h4a);
    rd(IFL_OFS_ACK_LP, 32'h56);
    wr(IFL_OFS_FORCE_LOW, 32'h200);
    ack(3'h5, 2'h3, 8'h49);
    rd(IFL_OFS_ACK_LP, 32'h52);
    // Fixed source answers at the midpoint
    wr(IFL_OFS_FORCE_LOW, 32'h10);
    ack(3'h4, 2'h1, 8'h44);
    rd(IFL_OFS_ACK_LP, 32'h48);
    // Unmasked pending source at a random priority
    acked_priority_field = 3'($urandom % 8);
    wr(IFL_OFS_FORCE_LOW, 32'h0);
    wr(IFL_OFS_CTRL_BASE + 7'h0b, {26'h0, 3'h6, acked_priority_field});
    src_req[11] <= 1'b1;
    wr(IFL_OFS_MASK_LOW, 32'hfffff7fe);
    ack(3'h6, 2'h2, 8'h4b);
    rd(IFL_OFS_ACK_LP, {25'h0, 3'h6, 1'h0, acked_priority_field});
    wr(IFL_OFS_MASK_LOW, 32'h1);
    rd(IFL_OFS_LEVEL_REQ, 32'h0);
    // Peer level and an acknowledge with nothing behind it
    peer_level_req <= 7'h40;
    ack(3'h0, 2'h0, 8'h18);
    cmp_ipl(3'h7);
    rd(IFL_OFS_ACK_LP, 32'h0);
    final_report();
  end
endmodule
